// ===== src/lncr_regs.sv
// Register bank for the serial links, static forwarding and the USB node
`timescale 1ns/1ns
`default_nettype none
module lncr_regs #(
  parameter logic [7:0] CHIP_ID   = 8'hA5, // Arbitrary value
  parameter logic [7:0] BLOCK_REV = 8'h01, // Arbitrary value
  parameter logic [7:0] BLOCK_VER = 8'h01  // Arbitrary value
) (
  input  wire logic                          clock_i,
  input  wire logic                          resetn_i,
  // Configuration access
  input  wire logic                          cfg_req_i,
  input  wire logic                          cfg_write_i,
  input  wire logic                          cfg_usb_node_i,
  input  wire logic [lncr_pkg::ADDR_W-1:0]   cfg_addr_i,
  input  wire logic [lncr_pkg::DATA_W-1:0]   cfg_wdata_i,
  output var  logic                          cfg_ack_o,
  output var  logic                          cfg_nack_o,
  output var  logic [lncr_pkg::DATA_W-1:0]   cfg_rdata_o,
  // External links 0..7
  input  wire logic [lncr_pkg::NUM_LINKS-1:0] link_rx_error_i,
  input  wire logic [lncr_pkg::NUM_LINKS-1:0] link_credit_issued_i,
  input  wire logic [lncr_pkg::NUM_LINKS-1:0] link_credit_held_i,
  output var  lncr_pkg::lncr_link_cfg_type    link_cfg_o [lncr_pkg::NUM_LINKS],
  output var  logic [lncr_pkg::NUM_LINKS-1:0] link_pin_sel_o,
  output var  logic [lncr_pkg::NUM_LINKS-1:0] link_hello_o,
  output var  logic [lncr_pkg::NUM_LINKS-1:0] link_rx_reset_o,
  output var  lncr_pkg::lncr_fwd_type         link_fwd_o [lncr_pkg::NUM_LINKS],
  // USB node link
  input  wire logic                          usb_link_rx_error_i,
  input  wire logic                          usb_link_credit_issued_i,
  input  wire logic                          usb_link_credit_held_i,
  output var  lncr_pkg::lncr_link_cfg_type   usb_link_cfg_o,
  output var  logic                          usb_link_hello_o,
  output var  logic                          usb_link_rx_reset_o,
  output var  lncr_pkg::lncr_usb_node_type   usb_node_o
);
  import lncr_pkg::*;

  // ****************************************************************
  // Storage: index NUM_LINKS is the USB node's own link
  // ****************************************************************
  localparam int unsigned NL = NUM_LINKS + 1;
  localparam logic [2:0]  LOW3 = 3'h7;

  lncr_link_cfg_type   lcfg_q [NL];
  logic [NL-1:0]       err_q;
  logic [NL-1:0]       hello_q;
  logic [NL-1:0]       rxrst_q;
  lncr_fwd_type        fwd_q [NUM_LINKS];
  lncr_usb_node_type   node_q;
  logic                ack_q;
  logic                nack_q;
  logic [DATA_W-1:0]   rdata_q;

  // ****************************************************************
  // Field packing
  // ****************************************************************
  function automatic logic [DATA_W-1:0] link_word(input lncr_link_cfg_type c,
                                                  input logic err,
                                                  input logic issued,
                                                  input logic held);
    logic [DATA_W-1:0] w;
    w = '0;
    w[LINK_EN_BIT]     = c.enable;
    w[LINK_WIDTH_BIT]  = c.five_wire;
    w[LINK_ERR_BIT]    = err;
    w[LINK_ISSUED_BIT] = issued;
    w[LINK_HELD_BIT]   = held;
    w[SYM_GAP_LSB +: GAP_W] = c.sym_gap;
    w[TOK_GAP_LSB +: GAP_W] = c.tok_gap;
    link_word = w;
  endfunction : link_word

  function automatic lncr_link_cfg_type link_unpack(input logic [DATA_W-1:0] w);
    lncr_link_cfg_type c;
    c.enable    = w[LINK_EN_BIT];
    c.five_wire = w[LINK_WIDTH_BIT];
    c.sym_gap   = w[SYM_GAP_LSB +: GAP_W];
    c.tok_gap   = w[TOK_GAP_LSB +: GAP_W];
    link_unpack = c;
  endfunction : link_unpack

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic       sw_link_hit  = !cfg_usb_node_i &&
                                  (cfg_addr_i[7:3] == LINK_SETUP_BASE[7:3]);
  wire logic       sw_fwd_hit   = !cfg_usb_node_i &&
                                  (cfg_addr_i[7:3] == STATIC_FWD_BASE[7:3]);
  wire logic       usb_id_hit   = cfg_usb_node_i && (cfg_addr_i == USB_IDENTITY_ADDR);
  wire logic       usb_cfg_hit  = cfg_usb_node_i && (cfg_addr_i == USB_NODE_CFG_ADDR);
  wire logic       usb_num_hit  = cfg_usb_node_i && (cfg_addr_i == USB_NODE_NUM_ADDR);
  wire logic       usb_clk_hit  = cfg_usb_node_i && (cfg_addr_i == SYS_CLK_MHZ_ADDR);
  wire logic       usb_link_hit = cfg_usb_node_i && (cfg_addr_i == USB_LINK_CTL_ADDR);
  wire logic [2:0] sub_idx      = cfg_addr_i[2:0] & LOW3;
  wire logic       hit          = sw_link_hit | sw_fwd_hit | usb_id_hit | usb_cfg_hit |
                                  usb_num_hit | usb_clk_hit | usb_link_hit;

  // Write qualification
  wire logic       wr           = cfg_req_i && cfg_write_i;
  wire logic [6:0] new_mhz      = cfg_wdata_i[CLK_MHZ_W-1:0];
  wire logic       mhz_ok       = (new_mhz >= CLK_MHZ_MIN) &&
                                  (new_mhz <= CLK_MHZ_MAX) &&
                                  (cfg_wdata_i[DATA_W-1:CLK_MHZ_W] == '0);
  wire logic       locked_hit   = node_q.lock && (usb_cfg_hit || usb_link_hit);
  wire logic       refuse_wr    = wr && (usb_id_hit || locked_hit ||
                                         (usb_clk_hit && !mhz_ok));
  wire logic       wr_ok        = wr && hit && !refuse_wr;

  // Link index addressed by a link-setup access, NUM_LINKS for the USB node link
  wire logic       link_wr      = wr_ok && (sw_link_hit || usb_link_hit);
  wire logic [3:0] link_idx     = usb_link_hit ? 4'(NUM_LINKS) : {1'b0, sub_idx};

  // ****************************************************************
  // Read data
  // ****************************************************************
  wire logic [NL-1:0] issued_all = {usb_link_credit_issued_i, link_credit_issued_i};
  wire logic [NL-1:0] held_all   = {usb_link_credit_held_i, link_credit_held_i};
  wire logic [NL-1:0] rxerr_all  = {usb_link_rx_error_i, link_rx_error_i};

  logic [DATA_W-1:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (sw_link_hit || usb_link_hit) begin
      rd_word = link_word(lcfg_q[link_idx], err_q[link_idx],
                          issued_all[link_idx], held_all[link_idx]);
    end else if (sw_fwd_hit) begin
      rd_word[FWD_EN_BIT]           = fwd_q[sub_idx].enable;
      rd_word[FWD_PROC_BIT]         = fwd_q[sub_idx].proc;
      rd_word[FWD_CHAN_W-1:0]       = fwd_q[sub_idx].chan_end;
    end else if (usb_id_hit) begin
      rd_word[ID_CHIP_LSB +: 8]     = CHIP_ID;
      rd_word[ID_REV_LSB +: 8]      = BLOCK_REV;
      rd_word[7:0]                  = BLOCK_VER;
    end else if (usb_cfg_hit) begin
      rd_word[NODE_LOCK_BIT]        = node_q.lock;
      rd_word[NODE_HDR_BIT]         = node_q.one_byte_hdr;
    end else if (usb_num_hit) begin
      rd_word[NODE_NUM_W-1:0]       = node_q.node_num;
    end else if (usb_clk_hit) begin
      rd_word[CLK_MHZ_W-1:0]        = node_q.clk_mhz;
    end
  end

  // ****************************************************************
  // Access response
  // ****************************************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q   <= 1'b0;
      nack_q  <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= cfg_req_i && hit && !refuse_wr;
      nack_q  <= cfg_req_i && (!hit || refuse_wr);
      rdata_q <= (cfg_req_i && !cfg_write_i) ? rd_word : '0;
    end
  end

  // ****************************************************************
  // Link setup registers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_link
      localparam logic [10:0] GAP_RST = (g == NUM_LINKS) ? USB_LINK_GAP_RST : LINK_GAP_RST;
      // The USB node link has no enable or width bits: they stay reserved
      localparam logic [DATA_W-1:0] KEEP = (g == NUM_LINKS) ? 32'h0FFF_FFFF : 32'hFFFF_FFFF;
      wire logic sel = link_wr && (link_idx == 4'(g));
      wire logic hello_set = sel && cfg_wdata_i[LINK_HELLO_BIT];
      wire logic rxrst_set = sel && cfg_wdata_i[LINK_RXRST_BIT];

      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          lcfg_q[g]  <= '{enable: 1'b0, five_wire: 1'b0, sym_gap: GAP_RST, tok_gap: GAP_RST};
          err_q[g]   <= 1'b0;
          hello_q[g] <= 1'b0;
          rxrst_q[g] <= 1'b0;
        end else begin
          if (sel) begin
            lcfg_q[g] <= link_unpack(cfg_wdata_i & KEEP);
          end
          // Error stays up until a receiver reset; a new error wins
          err_q[g]   <= rxerr_all[g] | (err_q[g] & ~rxrst_set);
          hello_q[g] <= hello_set;
          rxrst_q[g] <= rxrst_set;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Static forwarding registers
  // ****************************************************************
  generate
    for (g = 0; g < NUM_LINKS; g++) begin : g_fwd
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          fwd_q[g] <= '0;
        end else if (wr_ok && sw_fwd_hit && (sub_idx == 3'(g))) begin
          fwd_q[g].enable   <= cfg_wdata_i[FWD_EN_BIT];
          fwd_q[g].proc     <= cfg_wdata_i[FWD_PROC_BIT];
          fwd_q[g].chan_end <= cfg_wdata_i[FWD_CHAN_W-1:0];
        end
      end
      assign link_fwd_o[lncr_fwd_link(3'(g))] = fwd_q[g];
    end
  endgenerate

  // ****************************************************************
  // USB node registers
  // ****************************************************************
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      node_q.lock         <= 1'b0;
      node_q.one_byte_hdr <= 1'b0;
      node_q.node_num     <= '0;
      node_q.clk_mhz      <= CLK_MHZ_RST;
    end else if (wr_ok) begin
      if (usb_cfg_hit) begin
        node_q.lock         <= cfg_wdata_i[NODE_LOCK_BIT];
        node_q.one_byte_hdr <= cfg_wdata_i[NODE_HDR_BIT];
      end
      if (usb_num_hit) begin
        node_q.node_num <= cfg_wdata_i[NODE_NUM_W-1:0];
      end
      if (usb_clk_hit) begin
        node_q.clk_mhz <= new_mhz;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  generate
    for (g = 0; g < NUM_LINKS; g++) begin : g_out
      assign link_cfg_o[g]     = lcfg_q[g];
      assign link_pin_sel_o[g] = lcfg_q[g].enable;
    end
  endgenerate

  assign link_hello_o        = hello_q[NUM_LINKS-1:0];
  assign link_rx_reset_o     = rxrst_q[NUM_LINKS-1:0];
  assign usb_link_cfg_o      = lcfg_q[NUM_LINKS];
  assign usb_link_hello_o    = hello_q[NUM_LINKS];
  assign usb_link_rx_reset_o = rxrst_q[NUM_LINKS];
  assign usb_node_o          = node_q;
  assign cfg_ack_o           = ack_q;
  assign cfg_nack_o          = nack_q;
  assign cfg_rdata_o         = rdata_q;

endmodule : lncr_regs
`default_nettype wire

// ===== src/lncr_pkg.sv
// Package: constants and types of the link and node configuration register bank
package lncr_pkg;

  // ****************************************************************
  // Access port
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ****************************************************************
  // Switch node register numbers
  // ****************************************************************
  localparam logic [7:0] LINK_SETUP_BASE  = 8'h80;
  localparam logic [7:0] STATIC_FWD_BASE  = 8'hA0;
  localparam int unsigned NUM_LINKS       = 8;

  // ****************************************************************
  // USB node register numbers
  // ****************************************************************
  localparam logic [7:0] USB_IDENTITY_ADDR = 8'h00;
  localparam logic [7:0] USB_NODE_CFG_ADDR = 8'h04;
  localparam logic [7:0] USB_NODE_NUM_ADDR = 8'h05;
  localparam logic [7:0] SYS_CLK_MHZ_ADDR  = 8'h51;
  localparam logic [7:0] USB_LINK_CTL_ADDR = 8'h80;

  // ****************************************************************
  // Link setup field positions
  // ****************************************************************
  localparam int unsigned LINK_EN_BIT     = 31;
  localparam int unsigned LINK_WIDTH_BIT  = 30;
  localparam int unsigned LINK_ERR_BIT    = 27;
  localparam int unsigned LINK_ISSUED_BIT = 26;
  localparam int unsigned LINK_HELD_BIT   = 25;
  localparam int unsigned LINK_HELLO_BIT  = 24;
  localparam int unsigned LINK_RXRST_BIT  = 23;
  localparam int unsigned SYM_GAP_LSB     = 11;
  localparam int unsigned GAP_W           = 11;
  localparam int unsigned TOK_GAP_LSB     = 0;
  localparam logic [10:0] LINK_GAP_RST    = 11'h000;
  localparam logic [10:0] USB_LINK_GAP_RST = 11'h001;

  // ****************************************************************
  // Static forwarding field positions
  // ****************************************************************
  localparam int unsigned FWD_EN_BIT    = 31;
  localparam int unsigned FWD_PROC_BIT  = 8;
  localparam int unsigned FWD_CHAN_W    = 5;

  // ****************************************************************
  // USB node field positions and reset values
  // ****************************************************************
  localparam int unsigned NODE_LOCK_BIT  = 31;
  localparam int unsigned NODE_HDR_BIT   = 0;
  localparam int unsigned NODE_NUM_W     = 16;
  localparam int unsigned CLK_MHZ_W      = 7;
  localparam logic [6:0]  CLK_MHZ_RST    = 7'h19;
  localparam logic [6:0]  CLK_MHZ_MIN    = 7'h05;
  localparam logic [6:0]  CLK_MHZ_MAX    = 7'h64;
  localparam int unsigned ID_CHIP_LSB    = 24;
  localparam int unsigned ID_REV_LSB     = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic              enable;
    logic              five_wire;
    logic [GAP_W-1:0]  sym_gap;
    logic [GAP_W-1:0]  tok_gap;
  } lncr_link_cfg_type;

  typedef struct packed {
    logic                  enable;
    logic                  proc;
    logic [FWD_CHAN_W-1:0] chan_end;
  } lncr_fwd_type;

  typedef struct packed {
    logic                  lock;
    logic                  one_byte_hdr;
    logic [NODE_NUM_W-1:0] node_num;
    logic [CLK_MHZ_W-1:0]  clk_mhz;
  } lncr_usb_node_type;

  // Static register i serves links C,D,A,B,G,H,E,F in turn
  function automatic logic [2:0] lncr_fwd_link(input logic [2:0] idx);
    lncr_fwd_link = idx ^ 3'h2;
  endfunction : lncr_fwd_link

endpackage : lncr_pkg

// ===== verification/lncr_regs_properties.sv
// Checker: port properties of the link and node register bank
`timescale 1ns/1ns
`default_nettype none
module lncr_regs_properties (
  input wire logic                        clock_i,
  input wire logic                        resetn_i,
  input wire logic                        cfg_req_i,
  input wire logic                        cfg_write_i,
  input wire logic                        cfg_usb_node_i,
  input wire logic [7:0]                  cfg_addr_i,
  input wire logic [31:0]                 cfg_wdata_i,
  input wire logic                        cfg_ack_o,
  input wire logic                        cfg_nack_o,
  input wire lncr_pkg::lncr_link_cfg_type link_cfg_o [8],
  input wire logic [7:0]                  link_pin_sel_o,
  input wire logic [7:0]                  link_hello_o,
  input wire logic [7:0]                  link_rx_reset_o,
  input wire lncr_pkg::lncr_fwd_type      link_fwd_o [8],
  input wire lncr_pkg::lncr_usb_node_type usb_node_o
);
  import lncr_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  wire logic sw_wr  = cfg_req_i && cfg_write_i && !cfg_usb_node_i;
  wire logic usb_wr = cfg_req_i && cfg_write_i && cfg_usb_node_i;
  sequence wr_link0_s;
    sw_wr && cfg_addr_i == 8'h80;
  endsequence
  sequence bad_clk_s;
    usb_wr && cfg_addr_i == 8'h51 && (cfg_wdata_i < 32'h05 || cfg_wdata_i > 32'h64);
  endsequence
  sequence locked_wr_s;
    usb_wr && cfg_addr_i == 8'h04 && usb_node_o.lock;
  endsequence
  one_answer_a: assert property (cfg_req_i |=> cfg_ack_o ^ cfg_nack_o)
    else $error("request not answered by exactly one of ack and nack");
  link_enable_a: assert property (wr_link0_s |=> link_pin_sel_o[0] == $past(cfg_wdata_i[31])
      && link_cfg_o[0].enable == link_pin_sel_o[0])
    else $error("link enable or pin select not taken from bit 31");
  link_fields_a: assert property (wr_link0_s |=>
      link_cfg_o[0] == {$past(cfg_wdata_i[31:30]), $past(cfg_wdata_i[21:0])})
    else $error("link setup fields differ from written value");
  hello_cause_a: assert property (link_hello_o[0] |-> cfg_ack_o
      && $past(sw_wr && cfg_addr_i == 8'h80 && cfg_wdata_i[24]))
    else $error("greeting pulse without a write of bit 24");
  hello_pulse_a: assert property (wr_link0_s ##0 cfg_wdata_i[24] |=> link_hello_o[0])
    else $error("write of bit 24 gave no greeting pulse");
  rx_reset_a: assert property (wr_link0_s ##0 cfg_wdata_i[23] |=> link_rx_reset_o[0])
    else $error("write of bit 23 gave no receiver reset");
  static_map_a: assert property (sw_wr && cfg_addr_i == 8'hA0 |=> link_fwd_o[2] ==
      {$past(cfg_wdata_i[31]), $past(cfg_wdata_i[8]), $past(cfg_wdata_i[4:0])})
    else $error("first static register did not reach its link");
  clk_range_a: assert property (bad_clk_s |=> cfg_nack_o && $stable(usb_node_o.clk_mhz))
    else $error("out of range clock value not refused");
  lock_block_a: assert property (locked_wr_s |=> cfg_nack_o && $stable(usb_node_o))
    else $error("locked node configuration was changed");
endmodule : lncr_regs_properties
bind lncr_regs lncr_regs_properties u_props (
  .clock_i, .resetn_i, .cfg_req_i, .cfg_write_i, .cfg_usb_node_i, .cfg_addr_i, .cfg_wdata_i,
  .cfg_ack_o, .cfg_nack_o, .link_cfg_o, .link_pin_sel_o, .link_hello_o, .link_rx_reset_o,
  .link_fwd_o, .usb_node_o
);
`default_nettype wire

// ===== verification/lncr_link_peer.sv
// Remote link endpoint model: credit exchange and receive faults
`timescale 1ns/1ns
`default_nettype none
module lncr_link_peer #(
  parameter int N     = 8,
  parameter int DELAY = 4
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic [N-1:0] hello_i,
  input  wire logic [N-1:0] fault_i,
  output var  logic [N-1:0] rx_error_o,
  output var  logic [N-1:0] credit_issued_o,
  output var  logic [N-1:0] credit_held_o
);
  int wait_q [N];
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_error_o      <= '0;
      credit_issued_o <= '0;
      credit_held_o   <= '0;
      wait_q          <= '{default: 0};
    end else begin
      rx_error_o <= fault_i;
      for (int i = 0; i < N; i++) begin
        if (hello_i[i]) begin
          // Greeting drops credit; the far end answers DELAY cycles later
          credit_issued_o[i] <= 1'b0;
          credit_held_o[i]   <= 1'b0;
          wait_q[i]          <= DELAY;
        end else if (wait_q[i] == 1) begin
          credit_issued_o[i] <= 1'b1;
          credit_held_o[i]   <= 1'b1;
          wait_q[i]          <= 0;
        end else if (wait_q[i] > 1) begin
          wait_q[i] <= wait_q[i] - 1;
        end
      end
    end
  end
endmodule : lncr_link_peer
`default_nettype wire

// ===== verification/link_node_config_regs_tb.sv
// Self-checking bench for the link and node configuration register bank
`timescale 1ns/1ns
`default_nettype none
module link_node_config_regs_tb;
  import lncr_pkg::*;
  logic              clock_i, resetn_i, cfg_req_i, cfg_write_i, cfg_usb_node_i;
  logic              cfg_ack_o, cfg_nack_o, usb_link_hello_o, usb_link_rx_reset_o, uhs;
  logic              urs, usb_fault;
  logic              usb_link_rx_error_i, usb_link_credit_issued_i, usb_link_credit_held_i;
  logic [7:0]        cfg_addr_i, link_rx_error_i, link_credit_issued_i, link_credit_held_i;
  logic [7:0]        link_pin_sel_o, link_hello_o, link_rx_reset_o, fault, hs, rs;
  logic [31:0]       cfg_wdata_i, cfg_rdata_o, got;
  lncr_link_cfg_type link_cfg_o [8];
  lncr_link_cfg_type usb_link_cfg_o;
  lncr_fwd_type      link_fwd_o [8];
  lncr_usb_node_type usb_node_o;
  int                errors = 0, cmp_count = 0, cycles = 0;
  int                fwd_map [8] = '{2, 3, 0, 1, 6, 7, 4, 5};
  // Identity parameter values are arbitrary
  lncr_regs #(.CHIP_ID(8'h3C), .BLOCK_REV(8'h07), .BLOCK_VER(8'h09)) DUT (
    .clock_i, .resetn_i, .cfg_req_i, .cfg_write_i, .cfg_usb_node_i, .cfg_addr_i, .cfg_wdata_i,
    .cfg_ack_o, .cfg_nack_o, .cfg_rdata_o, .link_rx_error_i, .link_credit_issued_i,
    .link_credit_held_i, .link_cfg_o, .link_pin_sel_o, .link_hello_o, .link_rx_reset_o,
    .link_fwd_o, .usb_link_rx_error_i, .usb_link_credit_issued_i, .usb_link_credit_held_i,
    .usb_link_cfg_o, .usb_link_hello_o, .usb_link_rx_reset_o, .usb_node_o);
  lncr_link_peer u_peer (.clock_i, .resetn_i, .hello_i(link_hello_o),
    .fault_i(fault), .rx_error_o(link_rx_error_i), .credit_issued_o(link_credit_issued_i),
    .credit_held_o(link_credit_held_i));
  lncr_link_peer #(.N(1), .DELAY(1)) u_usb_peer (.clock_i, .resetn_i,
    .hello_i(usb_link_hello_o), .fault_i(usb_fault), .rx_error_o(usb_link_rx_error_i),
    .credit_issued_o(usb_link_credit_issued_i), .credit_held_o(usb_link_credit_held_i));
  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
      errors++;
    end
  endtask : check
  task automatic access(input logic u, w, input logic [7:0] a, input logic [31:0] d,
                        input logic ok);
    @(posedge clock_i);
    #1;
    {cfg_req_i, cfg_write_i, cfg_usb_node_i, cfg_addr_i, cfg_wdata_i} = {1'b1, w, u, a, d};
    @(posedge clock_i);
    #1;
    cfg_req_i = 1'b0;
    got = cfg_rdata_o;
    {hs, rs, uhs, urs} = {link_hello_o, link_rx_reset_o, usb_link_hello_o, usb_link_rx_reset_o};
    check({30'h0, cfg_ack_o, cfg_nack_o}, {30'h0, ok, !ok});
  endtask : access
  task automatic rd(input logic u, input logic [7:0] a, input logic [31:0] e);
    access(u, 1'b0, a, 32'h0, 1'b1);
    check(got, e);
  endtask : rd
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(1'b1, 8'h00, 32'h3C00_0709);
    rd(1'b1, 8'h04, 32'h0000_0000);
    rd(1'b1, 8'h05, 32'h0000_0000);
    rd(1'b1, 8'h51, 32'h0000_0019);
    rd(1'b1, 8'h80, 32'h0000_0801);
    rd(1'b0, 8'h80, 32'h0000_0000);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_links;
    for (int i = 0; i < 8; i++) begin
      access(1'b0, 1'b1, 8'h80 + 8'(i), 32'hF07F_FFFF, 1'b1);
      check({31'h0, link_pin_sel_o[i]}, 32'h1);
      check(32'(link_cfg_o[i]), 32'h00FF_FFFF);
      rd(1'b0, 8'h80 + 8'(i), 32'hC03F_FFFF);
      access(1'b0, 1'b1, 8'h80 + 8'(i), 32'h4000_0801, 1'b1);
      check({31'h0, link_pin_sel_o[i]}, 32'h0);
      rd(1'b0, 8'h80 + 8'(i), 32'h4000_0801);
    end
    access(1'b0, 1'b0, 8'h88, 32'h0, 1'b0);
    $display("test link setup done");
  endtask : t_links
  task automatic t_hello;
    access(1'b0, 1'b1, 8'h83, 32'h0100_0000, 1'b1);
    check({24'h0, hs}, 32'h0000_0008);
    access(1'b1, 1'b1, 8'h80, 32'hC100_0801, 1'b1);
    check({31'h0, uhs}, 32'h1);
    repeat (6) @(posedge clock_i);
    rd(1'b0, 8'h83, 32'h0600_0000);
    rd(1'b1, 8'h80, 32'h0600_0801);
    $display("test greeting and credit done");
  endtask : t_hello
  task automatic t_err;
    @(posedge clock_i);
    #1;
    {fault, usb_fault} = {8'h20, 1'b1};
    @(posedge clock_i);
    #1;
    {fault, usb_fault} = '0;
    repeat (2) @(posedge clock_i);
    rd(1'b0, 8'h85, 32'h4800_0801);
    rd(1'b0, 8'h85, 32'h4800_0801);
    access(1'b0, 1'b1, 8'h85, 32'h0080_0000, 1'b1);
    check({24'h0, rs}, 32'h0000_0020);
    rd(1'b0, 8'h85, 32'h0000_0000);
    rd(1'b1, 8'h80, 32'h0E00_0801);
    access(1'b1, 1'b1, 8'h80, 32'h0080_0801, 1'b1);
    check({31'h0, urs}, 32'h1);
    check(32'(usb_link_cfg_o), 32'h0000_0801);
    rd(1'b1, 8'h80, 32'h0600_0801);
    $display("test receive error done");
  endtask : t_err
  task automatic t_static;
    for (int i = 0; i < 8; i++) begin
      access(1'b0, 1'b1, 8'hA0 + 8'(i), {1'b1, 22'h3FFFFF, 1'(i), 3'h7, 5'(i + 3)}, 1'b1);
      check(32'(link_fwd_o[fwd_map[i]]), {25'h0, 1'b1, 1'(i), 5'(i + 3)});
      rd(1'b0, 8'hA0 + 8'(i), {1'b1, 22'h0, 1'(i), 3'h0, 5'(i + 3)});
    end
    access(1'b0, 1'b0, 8'hA8, 32'h0, 1'b0);
    $display("test static forwarding done");
  endtask : t_static
  task automatic t_clock;
    logic [31:0] v [5] = '{32'h04, 32'h05, 32'h64, 32'h65, 32'h85};
    logic [31:0] e = 32'h19;
    for (int i = 0; i < 5; i++) begin
      access(1'b1, 1'b1, 8'h51, v[i], v[i] >= 32'h05 && v[i] <= 32'h64);
      if (v[i] >= 32'h05 && v[i] <= 32'h64) e = v[i];
      rd(1'b1, 8'h51, e);
    end
    access(1'b1, 1'b1, 8'h00, 32'hFFFF_FFFF, 1'b0);
    rd(1'b1, 8'h00, 32'h3C00_0709);
    $display("test clock field done");
  endtask : t_clock
  task automatic t_lock;
    access(1'b1, 1'b1, 8'h05, 32'hFFFF_1234, 1'b1);
    rd(1'b1, 8'h05, 32'h0000_1234);
    access(1'b1, 1'b1, 8'h04, 32'h7FFF_FFFF, 1'b1);
    check({31'h0, usb_node_o.one_byte_hdr}, 32'h1);
    rd(1'b1, 8'h04, 32'h0000_0001);
    access(1'b1, 1'b1, 8'h04, 32'h8000_0000, 1'b1);
    access(1'b1, 1'b1, 8'h04, 32'h0000_0001, 1'b0);
    access(1'b1, 1'b1, 8'h80, 32'h0000_0000, 1'b0);
    rd(1'b1, 8'h04, 32'h8000_0000);
    rd(1'b1, 8'h80, 32'h0600_0801);
    $display("test node lock done");
  endtask : t_lock
  // ****************************************************************
  // Clock, sequence and watchdog
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    {resetn_i, cfg_req_i, cfg_write_i, cfg_usb_node_i, cfg_addr_i, cfg_wdata_i, fault} = '0;
    usb_fault = 1'b0;
    repeat (5) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    t_reset;
    t_links;
    t_hello;
    t_err;
    t_static;
    t_clock;
    t_lock;
    tally_and_finish;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      tally_and_finish;
    end
  end
endmodule : link_node_config_regs_tb
`default_nettype wire
